// *** rph_radio_packet_handler.sv ***
`timescale 1ns/1ps
`include "rph_regs.svh"
module rph_radio_packet_handler import rph_pkg::*; #(
  parameter int DEPTH = 64
) (
  input logic clock,
  input logic sys_rst,
  input rph_cfg_t cfg,
  input logic tx_start_strobe,
  input logic rx_start_strobe,
  input logic tx_fifo_flush_strobe,
  input logic rx_fifo_flush_strobe,
  input logic tx_wr_strobe,
  input logic [7:0] tx_wr_data,
  input logic rx_rd_strobe,
  output logic [7:0] rx_rd_data_ff,
  input logic status_fifo_select,
  output rph_chip_status_t chip_status_ff,
  output logic [7:0] line_tx_byte_ff,
  output logic line_tx_valid_ff,
  input logic line_tx_ready,
  input logic [7:0] line_rx_byte,
  input logic line_rx_valid,
  input logic [7:0] rssi_value,
  input logic [6:0] link_quality_value,
  output logic general_output_pin_0_ff,
  output logic general_output_pin_2_ff,
  output rph_pkt_status_t packet_status_register_ff,
  output logic [$clog2(DEPTH):0] rx_fill_count_ff,
  output logic [$clog2(DEPTH):0] tx_fill_count_ff
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [AW:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff, rx_pkt_wp_ff, tx_cnt, rx_cnt, rx_rp_nxt;
  rph_tx_state_t tx_st_ff;
  rph_rx_state_t rx_st_ff;
  logic [7:0] tx_cnt_ff, rx_cnt_ff, tx_head, tx_coded, rx_d, rx_crc_hi_ff;
  logic tx_first_ff, tx_pkt_ff, fec_pend_ff, rx_first_ff, rx_pkt_ff, rx_addr_ff;
  logic rx_half_ff, rx_ok_ff, rx_idx_ff, tx_load, tx_pop, tx_emit, rx_dv, rd_ok, rx_hit;
  logic [7:0] fec_lo_ff, tx_line0;
  logic [3:0] rx_hi_ff;
  logic [39:0] rx_hist_ff, rx_hist_n;
  logic [15:0] tx_crc, rx_crc;
  logic [7:0] tx_pn, rx_pn, rx_raw;
  logic rx_var, rx_end_pay;

  // rate-1/2 nibble code: each bit with its complement, order reversed to spread bursts
  function automatic logic [7:0] fec_enc(input logic [3:0] n);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 4; i++) begin
      e[2*i+1] = n[3-i];
      e[2*i] = ~n[3-i];
    end
    return e;
  endfunction

  function automatic logic [3:0] fec_dec(input logic [7:0] e);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 4; i++) begin
      n[3-i] = e[2*i+1];
    end
    return n;
  endfunction

  function automatic logic gdo_fn(input logic [5:0] sel, input logic [AW:0] rc,
                                  input logic [AW:0] tc);
    case (sel)
      `RPH_GDO_RX_THR: gdo_fn = rc >= {1'b0, cfg.fifo_threshold};
      `RPH_GDO_RX_END: gdo_fn = (rc >= {1'b0, cfg.fifo_threshold}) || (rx_st_ff == RX_END);
      `RPH_GDO_TX_THR: gdo_fn = tc >= {1'b0, cfg.fifo_threshold};
      `RPH_GDO_TX_FULL: gdo_fn = tc == FULL;
      `RPH_GDO_SYNC_PKT: gdo_fn = tx_pkt_ff || rx_pkt_ff;
      default: gdo_fn = 1'b0;
    endcase
  endfunction

  assign tx_cnt = tx_wp_ff - tx_rp_ff;
  assign rx_cnt = rx_wp_ff - rx_rp_ff;
  assign tx_head = tx_mem[tx_rp_ff[AW-1:0]];
  assign tx_load = !line_tx_valid_ff || line_tx_ready;
  assign tx_pop = tx_load && !fec_pend_ff && tx_st_ff == TX_DATA && tx_cnt != '0;
  assign tx_emit = tx_pop || (tx_load && !fec_pend_ff && tx_st_ff == TX_CRC);
  assign tx_coded = (tx_st_ff == TX_CRC ? (tx_cnt_ff[0] ? tx_crc[7:0] : tx_crc[15:8]) : tx_head)
                    ^ (cfg.whitening_enable ? tx_pn : 8'h00);
  assign tx_line0 = cfg.fec_interleave_enable ? fec_enc(tx_coded[7:4]) : tx_coded;

  rph_codec u_tx_codec (
    .clock(clock), .sys_rst(sys_rst),
    .init(tx_st_ff == TX_IDLE), .pn_step(tx_emit), .crc_step(tx_pop && cfg.crc_enable),
    .crc_data(tx_head), .crc_ff(tx_crc), .pn_byte(tx_pn)
  );

  always_ff @(posedge clock) begin
    if (tx_wr_strobe && tx_cnt != FULL) begin
      tx_mem[tx_wp_ff[AW-1:0]] <= tx_wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wp_ff <= '0;
    end else if (tx_wr_strobe && tx_cnt != FULL) begin
      tx_wp_ff <= tx_wp_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_ff <= TX_IDLE;
      tx_rp_ff <= '0;
      tx_cnt_ff <= 8'h00;
      tx_first_ff <= 1'b0;
      tx_pkt_ff <= 1'b0;
      fec_pend_ff <= 1'b0;
      fec_lo_ff <= 8'h00;
      line_tx_byte_ff <= 8'h00;
      line_tx_valid_ff <= 1'b0;
    end else begin
      if (line_tx_ready) begin
        line_tx_valid_ff <= 1'b0;
      end
      if (tx_pop) begin
        tx_rp_ff <= tx_rp_ff + 1'b1;
      end
      if (tx_emit) begin
        line_tx_byte_ff <= tx_line0;
        line_tx_valid_ff <= 1'b1;
        fec_pend_ff <= cfg.fec_interleave_enable;
        fec_lo_ff <= fec_enc(tx_coded[3:0]);
      end
      if (tx_load && fec_pend_ff) begin
        line_tx_byte_ff <= fec_lo_ff;
        line_tx_valid_ff <= 1'b1;
        fec_pend_ff <= 1'b0;
      end else begin
        case (tx_st_ff)
          TX_IDLE: begin
            if (tx_start_strobe) begin
              tx_st_ff <= TX_PRE;
              tx_cnt_ff <= cfg.preamble_count;
            end
          end
          TX_PRE: begin
            if (tx_load) begin
              line_tx_byte_ff <= `RPH_PREAMBLE_BYTE;
              line_tx_valid_ff <= 1'b1;
              if (tx_cnt_ff > 8'h01) begin
                tx_cnt_ff <= tx_cnt_ff - 8'h01;
              end else if (tx_cnt != '0) begin
                tx_st_ff <= TX_SYNC;
                tx_cnt_ff <= 8'h00;
              end
            end
          end
          TX_SYNC: begin
            if (tx_load) begin
              line_tx_byte_ff <= tx_cnt_ff[0] ? cfg.sync_word[7:0] : cfg.sync_word[15:8];
              line_tx_valid_ff <= 1'b1;
              tx_cnt_ff <= tx_cnt_ff + 8'h01;
              if (tx_cnt_ff == (cfg.sync_long ? 8'h03 : 8'h01)) begin
                tx_st_ff <= TX_DATA;
                tx_pkt_ff <= 1'b1;
                tx_first_ff <= cfg.length_mode_select == `RPH_LEN_VAR;
                tx_cnt_ff <= cfg.max_length_value;
              end
            end
          end
          TX_DATA: begin
            if (tx_load && tx_cnt == '0) begin
              tx_st_ff <= TX_STARVED;
            end else if (tx_pop) begin
              tx_first_ff <= 1'b0;
              tx_cnt_ff <= tx_first_ff ? tx_head : tx_cnt_ff - 8'h01;
              if (cfg.length_mode_select != `RPH_LEN_INF &&
                  (tx_first_ff ? tx_head == 8'h00 : tx_cnt_ff == 8'h01)) begin
                tx_st_ff <= cfg.crc_enable ? TX_CRC : TX_IDLE;
                tx_pkt_ff <= cfg.crc_enable;
                tx_cnt_ff <= 8'h00;
              end
            end
          end
          TX_CRC: begin
            if (tx_emit) begin
              tx_cnt_ff <= 8'h01;
              if (tx_cnt_ff[0]) begin
                tx_st_ff <= TX_IDLE;
                tx_pkt_ff <= 1'b0;
              end
            end
          end
          TX_STARVED: begin
            tx_pkt_ff <= 1'b0;
          end
          default: tx_st_ff <= TX_IDLE;
        endcase
      end
      if (tx_fifo_flush_strobe) begin
        tx_rp_ff <= tx_wp_ff;
        if (tx_st_ff == TX_STARVED) begin
          tx_st_ff <= TX_IDLE;
        end
      end
    end
  end

  // receive: sync search on raw bytes, then FEC decode and dewhiten
  assign rx_hist_n = {rx_hist_ff[31:0], line_rx_byte};
  assign rx_hit = rx_st_ff == RX_SEARCH && line_rx_valid && (cfg.sync_long ?
    (rx_hist_n[31:0] == {cfg.sync_word, cfg.sync_word} && rx_hist_n[39:32] == `RPH_PREAMBLE_BYTE) :
    (rx_hist_n[15:0] == cfg.sync_word && rx_hist_n[23:16] == `RPH_PREAMBLE_BYTE));
  assign rx_dv = (rx_st_ff == RX_DATA || rx_st_ff == RX_CRC) && line_rx_valid &&
                 (!cfg.fec_interleave_enable || rx_half_ff);
  assign rx_raw = cfg.fec_interleave_enable ? {rx_hi_ff, fec_dec(line_rx_byte)} : line_rx_byte;
  assign rx_d = rx_raw ^ (cfg.whitening_enable ? rx_pn : 8'h00);
  assign rx_var = cfg.length_mode_select == `RPH_LEN_VAR;
  assign rx_end_pay = cfg.length_mode_select != `RPH_LEN_INF &&
                      (rx_first_ff ? rx_d == 8'h00 : rx_cnt_ff == 8'h01);
  assign rd_ok = rx_rd_strobe && rx_cnt != '0;
  assign rx_rp_nxt = rx_rp_ff + {{AW{1'b0}}, rd_ok};

  rph_codec u_rx_codec (
    .clock(clock), .sys_rst(sys_rst),
    .init(rx_hit), .pn_step(rx_dv), .crc_step(rx_dv && rx_st_ff == RX_DATA),
    .crc_data(rx_d), .crc_ff(rx_crc), .pn_byte(rx_pn)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_rp_ff <= '0;
      rx_rd_data_ff <= 8'h00;
    end else if (rd_ok) begin
      rx_rd_data_ff <= rx_mem[rx_rp_ff[AW-1:0]];
      rx_rp_ff <= rx_rp_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_ff <= RX_IDLE;
      rx_wp_ff <= '0;
      rx_pkt_wp_ff <= '0;
      rx_hist_ff <= '0;
      rx_cnt_ff <= 8'h00;
      rx_first_ff <= 1'b0;
      rx_addr_ff <= 1'b0;
      rx_pkt_ff <= 1'b0;
      rx_half_ff <= 1'b0;
      rx_hi_ff <= 4'h0;
      rx_ok_ff <= 1'b1;
      rx_idx_ff <= 1'b0;
      rx_crc_hi_ff <= 8'h00;
    end else begin
      if ((rx_st_ff == RX_DATA || rx_st_ff == RX_CRC) && line_rx_valid &&
          cfg.fec_interleave_enable) begin
        rx_half_ff <= !rx_half_ff;
        rx_hi_ff <= fec_dec(line_rx_byte);
      end
      case (rx_st_ff)
        RX_IDLE: begin
          if (rx_start_strobe) begin
            rx_st_ff <= RX_SEARCH;
          end
        end
        RX_SEARCH: begin
          if (line_rx_valid) begin
            rx_hist_ff <= rx_hist_n;
          end
          if (rx_hit) begin
            rx_st_ff <= RX_DATA;
            rx_pkt_ff <= 1'b1;
            rx_half_ff <= 1'b0;
            rx_hist_ff <= '0;
            rx_pkt_wp_ff <= rx_wp_ff;
            rx_first_ff <= rx_var;
            rx_addr_ff <= cfg.addr_check_enable && !rx_var;
            rx_cnt_ff <= cfg.max_length_value;
          end
        end
        RX_DATA: begin
          if (rx_dv) begin
            if ((rx_first_ff && rx_d > cfg.max_length_value) ||
                (rx_addr_ff && rx_d != cfg.node_address)) begin
              rx_st_ff <= RX_SEARCH;
              rx_pkt_ff <= 1'b0;
              rx_wp_ff <= rx_pkt_wp_ff;
            end else begin
              if (rx_cnt != FULL) begin
                rx_mem[rx_wp_ff[AW-1:0]] <= rx_d;
                rx_wp_ff <= rx_wp_ff + 1'b1;
              end
              rx_first_ff <= 1'b0;
              rx_addr_ff <= rx_first_ff && cfg.addr_check_enable;
              rx_cnt_ff <= rx_first_ff ? rx_d : rx_cnt_ff - 8'h01;
              if (rx_end_pay) begin
                rx_st_ff <= cfg.crc_enable ? RX_CRC : RX_END;
                rx_ok_ff <= 1'b1;
                rx_idx_ff <= 1'b0;
              end
            end
          end
        end
        RX_CRC: begin
          if (rx_dv) begin
            rx_idx_ff <= 1'b1;
            rx_crc_hi_ff <= rx_d;
            if (rx_idx_ff) begin
              rx_ok_ff <= {rx_crc_hi_ff, rx_d} == rx_crc;
              rx_st_ff <= RX_END;
            end
          end
        end
        RX_END: begin
          rx_idx_ff <= 1'b0;
          if (cfg.crc_fail_flush_enable && !rx_ok_ff) begin
            rx_wp_ff <= rx_rp_nxt;
          end
          if (cfg.status_append_enable && !(cfg.crc_fail_flush_enable && !rx_ok_ff)) begin
            rx_st_ff <= RX_STAT;
          end else begin
            rx_st_ff <= cfg.rx_exit_state_select == `RPH_EXIT_RX ? RX_SEARCH : RX_IDLE;
            rx_pkt_ff <= 1'b0;
          end
        end
        RX_STAT: begin
          if (rx_cnt != FULL) begin
            rx_mem[rx_wp_ff[AW-1:0]] <= rx_idx_ff ? rph_status2_t'({rx_ok_ff, link_quality_value})
                                                  : rssi_value;
            rx_wp_ff <= rx_wp_ff + 1'b1;
          end
          rx_idx_ff <= 1'b1;
          if (rx_idx_ff) begin
            rx_st_ff <= cfg.rx_exit_state_select == `RPH_EXIT_RX ? RX_SEARCH : RX_IDLE;
            rx_pkt_ff <= 1'b0;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
      if (rx_fifo_flush_strobe) begin
        rx_wp_ff <= rx_rp_nxt;
      end
    end
  end

  // fill and chip status mirrors lag the FIFOs by one cycle, packet status by two; the host tolerates this like any poll
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      general_output_pin_0_ff <= 1'b0;
      general_output_pin_2_ff <= 1'b0;
      packet_status_register_ff <= '0;
      rx_fill_count_ff <= '0;
      tx_fill_count_ff <= '0;
      chip_status_ff <= '0;
    end else begin
      general_output_pin_0_ff <= gdo_fn(cfg.general_output_pin_0_select, rx_cnt, tx_cnt);
      general_output_pin_2_ff <= gdo_fn(cfg.general_output_pin_2_select, rx_cnt, tx_cnt);
      packet_status_register_ff <= {general_output_pin_2_ff, general_output_pin_0_ff};
      rx_fill_count_ff <= rx_cnt;
      tx_fill_count_ff <= tx_cnt;
      chip_status_ff.tx_starved <= tx_st_ff == TX_STARVED;
      chip_status_ff.rx_busy <= rx_st_ff != RX_IDLE;
      chip_status_ff.tx_busy <= tx_st_ff != TX_IDLE;
      chip_status_ff.spare <= 1'b0;
      chip_status_ff.fill <= (status_fifo_select ? rx_cnt : tx_cnt) > AW'(`RPH_FILL_CAP) ?
        `RPH_FILL_CAP : (status_fifo_select ? rx_cnt[3:0] : tx_cnt[3:0]);
    end
  end

  chk_len_drop: assert property (@(posedge clock) disable iff (sys_rst)
    rx_st_ff == RX_DATA && rx_dv && rx_first_ff && rx_d > cfg.max_length_value
    |=> rx_st_ff == RX_SEARCH && rx_wp_ff == $past(rx_pkt_wp_ff)) else $error("oversize kept");
  chk_crc_flush: assert property (@(posedge clock) disable iff (sys_rst)
    rx_st_ff == RX_END && cfg.crc_fail_flush_enable && !rx_ok_ff && !rx_rd_strobe
    |=> rx_wp_ff == rx_rp_ff) else $error("rx fifo not flushed on crc fail");
  chk_starve_hold: assert property (@(posedge clock) disable iff (sys_rst)
    tx_st_ff == TX_STARVED && !tx_fifo_flush_strobe |=> tx_st_ff == TX_STARVED)
    else $error("left starved state without flush");
  chk_pre_byte: assert property (@(posedge clock) disable iff (sys_rst)
    tx_st_ff == TX_PRE && tx_load && !fec_pend_ff |=> line_tx_valid_ff &&
    line_tx_byte_ff == `RPH_PREAMBLE_BYTE) else $error("preamble byte wrong");
  chk_plain_data: assert property (@(posedge clock) disable iff (sys_rst)
    tx_pop && tx_st_ff == TX_DATA && !cfg.whitening_enable && !cfg.fec_interleave_enable
    |=> line_tx_byte_ff == $past(tx_head)) else $error("unwhitened byte altered");
  chk_sync_hunt: assert property (@(posedge clock) disable iff (sys_rst)
    rx_hit |=> rx_st_ff == RX_DATA && rx_pkt_ff) else $error("sync not taken");
  chk_gdo_pkt: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.general_output_pin_0_select == `RPH_GDO_SYNC_PKT |=> general_output_pin_0_ff ==
    $past(tx_pkt_ff || rx_pkt_ff)) else $error("pin does not follow packet");
  chk_pin_status: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 packet_status_register_ff == $past({general_output_pin_2_ff, general_output_pin_0_ff}, 1)
    && rx_fill_count_ff == $past(rx_cnt)) else $error("status mirror wrong");
endmodule // rph_radio_packet_handler

// *** rph_regs.svh ***
`ifndef RPH_REGS_SVH
`define RPH_REGS_SVH
`define RPH_LEN_VAR 2'h1
`define RPH_LEN_INF 2'h2
`define RPH_PREAMBLE_BYTE 8'haa
`define RPH_EXIT_RX 2'h3
`define RPH_GDO_RX_THR 6'h00
`define RPH_GDO_RX_END 6'h01
`define RPH_GDO_TX_THR 6'h02
`define RPH_GDO_TX_FULL 6'h03
`define RPH_GDO_SYNC_PKT 6'h06
`define RPH_CRC_INIT 16'hffff
`define RPH_CRC_POLY 16'h8005
`define RPH_PN9_INIT 9'h1ff
`define RPH_FILL_CAP 4'hf
`endif

// *** rph_pkg.sv ***
package rph_pkg;
  typedef struct packed {
    logic [1:0] length_mode_select;
    logic [7:0] max_length_value;
    logic crc_enable;
    logic crc_fail_flush_enable;
    logic status_append_enable;
    logic whitening_enable;
    logic fec_interleave_enable;
    logic addr_check_enable;
    logic [7:0] node_address;
    logic [7:0] preamble_count;
    logic [15:0] sync_word;
    logic sync_long;
    logic [1:0] rx_exit_state_select;
    logic [5:0] general_output_pin_0_select;
    logic [5:0] general_output_pin_2_select;
    logic [5:0] fifo_threshold;
  } rph_cfg_t;
  typedef struct packed {
    logic tx_starved;
    logic rx_busy;
    logic tx_busy;
    logic spare;
    logic [3:0] fill;
  } rph_chip_status_t;
  typedef struct packed {
    logic general_output_pin_2;
    logic general_output_pin_0;
  } rph_pkt_status_t;
  typedef struct packed {
    logic crc_pass_flag;
    logic [6:0] link_quality_value;
  } rph_status2_t;
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_PRE = 6'h02, TX_SYNC = 6'h04,
    TX_DATA = 6'h08, TX_CRC = 6'h10, TX_STARVED = 6'h20
  } rph_tx_state_t;
  typedef enum logic [5:0] {
    RX_IDLE = 6'h01, RX_SEARCH = 6'h02, RX_DATA = 6'h04,
    RX_CRC = 6'h08, RX_END = 6'h10, RX_STAT = 6'h20
  } rph_rx_state_t;
endpackage

// *** rph_codec.sv ***
`timescale 1ns/1ps
`include "rph_regs.svh"
module rph_codec (
  input logic clock,
  input logic sys_rst,
  input logic init,
  input logic pn_step,
  input logic crc_step,
  input logic [7:0] crc_data,
  output logic [15:0] crc_ff,
  output logic [7:0] pn_byte
);
  logic [8:0] pn_ff;

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ `RPH_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // eight steps of x^9+x^5+1 per byte, low bits go out first
  function automatic logic [8:0] pn_adv(input logic [8:0] s);
    logic [8:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[0] ^ r[5], r[8:1]};
    end
    return r;
  endfunction

  assign pn_byte = pn_ff[7:0];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crc_ff <= `RPH_CRC_INIT;
    end else if (init) begin
      crc_ff <= `RPH_CRC_INIT;
    end else if (crc_step) begin
      crc_ff <= crc_upd(crc_ff, crc_data);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pn_ff <= `RPH_PN9_INIT;
    end else if (init) begin
      pn_ff <= `RPH_PN9_INIT;
    end else if (pn_step) begin
      pn_ff <= pn_adv(pn_ff);
    end
  end

  chk_pn_seed: assert property (@(posedge clock) disable iff (sys_rst)
    init |=> pn_ff == `RPH_PN9_INIT) else $error("pn9 not seeded to all ones");
endmodule // rph_codec

// *** rph_line_model.sv ***
`timescale 1ns/1ps
module rph_line_model (
  input wire logic clock,
  input wire logic [7:0] line_tx_byte_ff,
  input wire logic line_tx_valid_ff,
  output logic line_tx_ready
);
  logic [7:0] got[$];
  logic [1:0] cnt = 2'h0;
  // refuses one cycle in four so the sender must hold its byte
  assign line_tx_ready = (cnt != 2'h3);
  always @(posedge clock) begin
    cnt <= cnt + 2'h1;
    if (line_tx_valid_ff && line_tx_ready) got.push_back(line_tx_byte_ff);
  end
endmodule // rph_line_model

// *** radio_packet_handler_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module radio_packet_handler_tb;
  import rph_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, tx_start_strobe = 1'b0, rx_start_strobe = 1'b0;
  logic tx_fifo_flush_strobe = 1'b0, tx_wr_strobe = 1'b0, rx_rd_strobe = 1'b0;
  logic status_fifo_select = 1'b0;
  logic line_rx_valid = 1'b0, line_tx_ready, line_tx_valid_ff;
  logic [7:0] tx_wr_data = 8'h0, line_rx_byte = 8'h0, rssi_value = 8'h5a, rx_rd_data_ff;
  logic [7:0] line_tx_byte_ff;
  logic [6:0] link_quality_value = 7'h21, rx_fill_count_ff, tx_fill_count_ff;
  logic general_output_pin_0_ff, general_output_pin_2_ff;
  rph_cfg_t cfg = '0;
  rph_chip_status_t chip_status_ff;
  rph_pkt_status_t packet_status_register_ff;
  int error_cnt = 0, compares = 0;
  logic [7:0] q[$];
  logic [15:0] c;
  always #25 clock = ~clock;
  rph_radio_packet_handler u_rph_radio_packet_handler (.clock, .sys_rst, .cfg,
    .tx_start_strobe, .rx_start_strobe, .tx_fifo_flush_strobe,
    .rx_fifo_flush_strobe(1'b0), .tx_wr_strobe, .tx_wr_data, .rx_rd_strobe,
    .rx_rd_data_ff, .status_fifo_select, .chip_status_ff, .line_tx_byte_ff,
    .line_tx_valid_ff, .line_tx_ready, .line_rx_byte, .line_rx_valid, .rssi_value,
    .link_quality_value, .general_output_pin_0_ff, .general_output_pin_2_ff,
    .packet_status_register_ff, .rx_fill_count_ff, .tx_fill_count_ff);
  rph_line_model u_rph_line_model (.clock, .line_tx_byte_ff, .line_tx_valid_ff,
    .line_tx_ready);
  // reference checksum over q from index 'from' on, msb first
  function automatic logic [15:0] crc16(int from);
    logic [15:0] r = 16'hffff;
    for (int i = from; i < q.size(); i++)
      for (int b = 7; b >= 0; b--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ q[i][b]) ? 16'h8005 : 16'h0);
    return r;
  endfunction
  task wr(logic [7:0] d);
    @(posedge clock); tx_wr_data <= d; tx_wr_strobe <= 1'b1;
    @(posedge clock); tx_wr_strobe <= 1'b0;
  endtask
  task rd_chk(logic [7:0] e);
    @(posedge clock); rx_rd_strobe <= 1'b1;
    @(posedge clock); rx_rd_strobe <= 1'b0;
    #1 `CHK(rx_rd_data_ff, e, "rx byte")
  endtask
  // plays q into the receiver back to back, then lets the packet end settle
  task send;
    foreach (q[i]) begin
      @(posedge clock); line_rx_valid <= 1'b1; line_rx_byte <= q[i];
    end
    @(posedge clock); line_rx_valid <= 1'b0; line_rx_byte <= ~line_rx_byte;
    repeat (12) @(posedge clock);
  endtask
  // preamble, sync, length, two data bytes and checksum
  task frame(logic [7:0] len, logic bad);
    q = '{8'haa, 8'hd3, 8'h91, len, 8'ha1, 8'ha2};
    c = crc16(3) ^ {15'h0, bad};
    q.push_back(c[15:8]); q.push_back(c[7:0]);
    send;
  endtask
  task t_tx;
    cfg.general_output_pin_0_select <= 6'h06;
    wr(8'h11); wr(8'h22); wr(8'h33);
    repeat (3) @(posedge clock);
    `CHK(tx_fill_count_ff, 7'h3, "tx fill")
    `CHK(chip_status_ff.fill, 4'h3, "tx status fill")
    tx_start_strobe <= 1'b1; @(posedge clock); tx_start_strobe <= 1'b0;
    for (int i = 0; i < 300 && u_rph_line_model.got.size() < 5; i++) @(posedge clock);
    `CHK(general_output_pin_0_ff, 1'b1, "pin in packet")
    for (int i = 0; i < 300 && u_rph_line_model.got.size() < 9; i++) @(posedge clock);
    repeat (2) @(posedge clock);
    `CHK(general_output_pin_0_ff, 1'b0, "pin after packet")
    q = '{8'h11, 8'h22, 8'h33}; c = crc16(0);
    q = '{8'haa, 8'haa, 8'hd3, 8'h91, 8'h11, 8'h22, 8'h33, c[15:8], c[7:0]};
    `CHK(u_rph_line_model.got.size(), 9, "tx count")
    foreach (q[i]) `CHK(u_rph_line_model.got[i], q[i], "tx byte")
  endtask
  task t_rx;
    cfg.length_mode_select <= 2'h1; cfg.max_length_value <= 8'h4;
    cfg.status_append_enable <= 1'b1; cfg.crc_fail_flush_enable <= 1'b1;
    cfg.general_output_pin_0_select <= 6'h01; cfg.fifo_threshold <= 6'h4;
    @(posedge clock); rx_start_strobe <= 1'b1; @(posedge clock); rx_start_strobe <= 1'b0;
    frame(8'h5, 1'b0);
    `CHK(rx_fill_count_ff, 7'h0, "oversize kept")
    frame(8'h2, 1'b0); // receiver must still be hunting despite idle exit choice
    `CHK(rx_fill_count_ff, 7'h5, "rx fill")
    `CHK(general_output_pin_0_ff, 1'b1, "pin level")
    `CHK(packet_status_register_ff.general_output_pin_0, 1'b1, "pin status")
    status_fifo_select <= 1'b1; repeat (2) @(posedge clock);
    `CHK(chip_status_ff.fill, 4'h5, "rx status fill")
    rd_chk(8'h2); rd_chk(8'ha1); rd_chk(8'ha2);
    rd_chk(8'h5a); rd_chk(8'ha1);
    repeat (3) @(posedge clock);
    `CHK(general_output_pin_0_ff, 1'b0, "pin drained")
    @(posedge clock); rx_start_strobe <= 1'b1; @(posedge clock); rx_start_strobe <= 1'b0;
    frame(8'h2, 1'b1);
    `CHK(rx_fill_count_ff, 7'h0, "bad crc kept")
  endtask
  task t_starve;
    cfg.length_mode_select <= 2'h0; cfg.max_length_value <= 8'h3;
    wr(8'h44);
    tx_start_strobe <= 1'b1; @(posedge clock); tx_start_strobe <= 1'b0;
    repeat (60) @(posedge clock);
    `CHK(chip_status_ff.tx_starved, 1'b1, "starved")
    wr(8'h55); repeat (20) @(posedge clock);
    `CHK(chip_status_ff.tx_starved, 1'b1, "write restarted")
    tx_fifo_flush_strobe <= 1'b1; @(posedge clock); tx_fifo_flush_strobe <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(chip_status_ff.tx_starved, 1'b0, "flush exit")
  endtask
  // coded frame looped back: receive must undo whitening and FEC of transmit
  task t_loop;
    cfg.length_mode_select <= 2'h1; cfg.max_length_value <= 8'h4; cfg.sync_long <= 1'b1;
    cfg.whitening_enable <= 1'b1; cfg.fec_interleave_enable <= 1'b1;
    cfg.addr_check_enable <= 1'b1; cfg.node_address <= 8'h3c;
    cfg.status_append_enable <= 1'b0; cfg.rx_exit_state_select <= 2'h3;
    u_rph_line_model.got.delete();
    wr(8'h2); wr(8'h3c); wr(8'h77);
    tx_start_strobe <= 1'b1; @(posedge clock); tx_start_strobe <= 1'b0;
    for (int i = 0; i < 300 && u_rph_line_model.got.size() < 16; i++) @(posedge clock);
    q = u_rph_line_model.got;
    `CHK(q.size(), 16, "coded count")
    `CHK(q[6], 8'haa, "whitened length")
    for (int i = 6; i < 16; i++) `CHK((q[i] ^ (q[i] >> 1)) & 8'h55, 8'h55, "fec pairs")
    rx_start_strobe <= 1'b1; @(posedge clock); rx_start_strobe <= 1'b0;
    send;
    `CHK(rx_fill_count_ff, 7'h3, "loop fill")
    rd_chk(8'h2); rd_chk(8'h3c); rd_chk(8'h77);
  endtask
  task summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cfg.preamble_count = 8'h2; cfg.sync_word = 16'hd391;
    cfg.max_length_value = 8'h3; cfg.crc_enable = 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    #1 `CHK(rx_fill_count_ff, 7'h0, "reset fill")
    t_tx; t_rx; t_starve; t_loop;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    summarize;
  end
endmodule // radio_packet_handler_tb
